//--- ict_bus_engine.sv
// instruction cycle timing: one bus read or write cycle at a time
// assumes bus_ready is synchronous and sampled on the last phase
`timescale 1ns/100ps
module ict_bus_engine import ict_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic bus_ready,
  ict_bus_if.eng   bus
);

  // ==========================================================
  // phase counting
  logic       active_r;
  logic       write_r;
  logic [1:0] phase_r;
  logic       last;
  logic       rd_r;
  logic       wr_r;

  assign last          = active_r && (phase_r == BUS_LAST_PHASE);
  assign bus.stall     = last && !bus_ready;
  assign bus.fin       = last && bus_ready;
  assign bus.can_issue = !active_r;
  assign bus.rd_strobe = rd_r;
  assign bus.wr_strobe = wr_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_r <= 1'b0;
      write_r  <= 1'b0;
      phase_r  <= 2'h0;
    end else if (bus.start) begin
      active_r <= 1'b1;
      write_r  <= bus.is_write;
      phase_r  <= 2'h1;
    end else if (bus.fin) begin
      active_r <= 1'b0;
    end else if (active_r && (phase_r != BUS_LAST_PHASE)) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // ==========================================================
  // strobes, one clock behind the cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      rd_r <= (bus.start && !bus.is_write) || (active_r && !write_r);
      wr_r <= (bus.start && bus.is_write) || (active_r && write_r);
    end
  end

endmodule // ict_bus_engine

//--- ict_bus_if.sv
// instruction cycle timing: link between sequencer and bus cycle engine
// assumes both ends share one clock
`timescale 1ns/100ps
interface ict_bus_if;
  logic start;
  logic is_write;
  logic stall;
  logic can_issue;
  logic fin;
  logic rd_strobe;
  logic wr_strobe;

  modport seq (output start, is_write, input stall, can_issue, fin, rd_strobe, wr_strobe);
  modport eng (input start, is_write, output stall, can_issue, fin, rd_strobe, wr_strobe);
endinterface

//--- ict_mem_model.sv
// memory model: answers bus cycles of the sequencer with bus_ready
// assumes bus_read_r/bus_write_r lag the internal cycle by one clock
`timescale 1ns/100ps
module ict_mem_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       bus_read_r,
  input  wire logic       bus_write_r,
  input  wire logic [3:0] waits,
  output logic            bus_ready
);
  // ==========================================================
  // clock count since the strobes rose, not cleared between back-to-back bus cycles
  logic [7:0] phase_r;
  wire        act = bus_read_r | bus_write_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) phase_r <= 8'h00;
    else if (!act) phase_r <= 8'h00;
    else phase_r <= phase_r + 8'h01;
  end
  // ready low for waits clocks from the 4th clock of the first bus cycle after strobes rise, else no wait states
  assign bus_ready = !(act && phase_r >= 8'h02 && phase_r < 8'h02 + {4'h0, waits});
endmodule // ict_mem_model

//--- ict_pkg.sv
// instruction cycle timing: shared constants, enumerations and widths
// assumes one clock domain; all counts are in clock periods
package ict_pkg;

  // ==========================================================
  // widths
  localparam int CLK_W = 9;
  localparam int RW_W  = 4;
  localparam int EA_W  = 8;
  localparam int SHN_W = 6;

  // ==========================================================
  // bus cycle length without wait states
  localparam logic [CLK_W-1:0] BUS_CYCLE_CLKS = 9'h004;
  localparam logic [1:0]       BUS_LAST_PHASE = 2'h3;

  // ==========================================================
  // base clock counts per instruction group
  localparam logic [CLK_W-1:0] STD_REG_BW       = 9'h004;
  localparam logic [CLK_W-1:0] STD_REG_L        = 9'h006;
  localparam logic [CLK_W-1:0] STD_REG_L_DIRECT = 9'h008;
  localparam logic [CLK_W-1:0] STD_ADDR_BW      = 9'h008;
  localparam logic [CLK_W-1:0] CMP_ADDR         = 9'h006;
  localparam logic [CLK_W-1:0] STD_MEM_BW       = 9'h008;
  localparam logic [CLK_W-1:0] STD_MEM_L        = 9'h00C;
  localparam logic [CLK_W-1:0] XOR_REG_L        = 9'h008;
  localparam logic [CLK_W-1:0] SDIV_CLKS        = 9'h09E;
  localparam logic [CLK_W-1:0] UDIV_CLKS        = 9'h08C;
  localparam logic [CLK_W-1:0] MUL_BASE         = 9'h026;
  localparam logic [CLK_W-1:0] MUL_MAX          = 9'h046;
  localparam logic [CLK_W-1:0] IMM_REG_BW       = 9'h008;
  localparam logic [CLK_W-1:0] IMM_REG_L        = 9'h010;
  localparam logic [CLK_W-1:0] IMM_MEM_BW       = 9'h00C;
  localparam logic [CLK_W-1:0] IMM_MEM_L        = 9'h014;
  localparam logic [CLK_W-1:0] SGL_REG_BW       = 9'h004;
  localparam logic [CLK_W-1:0] SGL_REG_L        = 9'h006;
  localparam logic [CLK_W-1:0] SHF_REG_BW       = 9'h006;
  localparam logic [CLK_W-1:0] SHF_REG_L        = 9'h008;
  localparam logic [CLK_W-1:0] SHF_MEM          = 9'h008;
  localparam logic [CLK_W-1:0] SCC_FALSE        = 9'h004;
  localparam logic [CLK_W-1:0] SCC_TRUE         = 9'h006;
  localparam logic [CLK_W-1:0] SCC_MEM          = 9'h008;
  localparam logic [CLK_W-1:0] BIT_DYN_MEM      = 9'h008;
  localparam logic [CLK_W-1:0] BIT_STAT_MEM     = 9'h00C;
  localparam logic [CLK_W-1:0] BIT_DYN_REG      = 9'h008;
  localparam logic [CLK_W-1:0] BIT_STAT_REG     = 9'h00C;

  // ==========================================================
  // enumerations
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP, OP_XOR,
    OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE, OP_SIGNED_MULTIPLY, OP_UNSIGNED_MULTIPLY,
    OP_IMMEDIATE, OP_SINGLE, OP_SHIFT, OP_SET_COND, OP_BIT_CHANGE
  } ict_op_t;

  typedef enum logic [1:0] {DST_DATA, DST_ADDR, DST_MEM} ict_dst_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} ict_size_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} ict_state_t;

endpackage

//--- ict_sequencer.sv
// instruction cycle timing: per-instruction clock and bus cycle sequencer
// assumes decoded instruction fields are held while instr_valid is high
//
// Contract
// - clock count covers operation, result store and next word fetch
// - flagged entries add effective address clocks and reads; writes come from the base entry only
// - exactly the given reads and writes are run, counted apart
// - long add, subtract, and, or take 8 not 6 with register or immediate source
// - xor into data register needs data register source; 4 or 8 clocks
// - signed divide 158, unsigned divide 140 clocks plus address time
// - multiply takes 38 plus 2n clocks, one read, at most 70
// - unsigned multiply n is count of one bits in source
// - signed multiply n is count of bit changes in source with zero appended
// - immediate forms include reads for their extension words
// - address register destination never takes byte size
// - index register size has no effect on time
// - register shifts 6 or 8 plus 2n; memory shifts word only, 8 clocks
// - set on condition to register takes 4 if false, 6 if true
// - memory bit change 8 clocks dynamic, 12 clocks static, plus address time
// - every bus cycle takes four clocks without wait states
// - wait states lengthen the instruction by exactly the added clocks
// - shift n is number of positions shifted
`timescale 1ns/100ps
module ict_sequencer import ict_pkg::*; (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         instr_valid,
  input  wire ict_op_t      instr_op,
  input  wire ict_size_t    instr_size,
  input  wire ict_dst_t     instr_dst,
  input  wire logic         src_reg_or_imm,
  input  wire logic         src_data_reg,
  input  wire logic [EA_W-1:0]  ea_clks,
  input  wire logic [RW_W-1:0]  ea_reads,
  input  wire logic [15:0]  src_value,
  input  wire logic [SHN_W-1:0] shift_count,
  input  wire logic         cond_true,
  input  wire logic         bit_static,
  input  wire logic         bus_ready,
  output logic              decode_ready_r,
  output logic              instr_done_r,
  output logic              illegal_r,
  output logic              bus_read_r,
  output logic              bus_write_r,
  output logic [CLK_W-1:0]  clocks_used_r,
  output logic [RW_W-1:0]   reads_done_r,
  output logic [RW_W-1:0]   writes_done_r
);

  // ==========================================================
  // helpers
  function automatic logic [CLK_W-1:0] ones16(input logic [15:0] v);
    logic [CLK_W-1:0] n;
    n = '0;
    for (int i = 0; i < 16; i++) begin
      n = n + {8'h00, v[i]};
    end
    return n;
  endfunction

  function automatic logic [CLK_W-1:0] changes17(input logic [15:0] v);
    logic [16:0] w;
    logic [CLK_W-1:0] n;
    w = {v, 1'b0};
    n = '0;
    for (int i = 0; i < 16; i++) begin
      n = n + {8'h00, w[i+1] ^ w[i]};
    end
    return n;
  endfunction

  function automatic logic [CLK_W-1:0] bus_clks(input logic [RW_W-1:0] n);
    return {5'h00, n} * BUS_CYCLE_CLKS;
  endfunction

  // ==========================================================
  // base timing decode
  ict_bus_if bus ();

  logic [CLK_W-1:0] tm_clks;
  logic [RW_W-1:0]  tm_rd;
  logic [RW_W-1:0]  tm_wr;
  logic             tm_ok;
  logic             tm_ea;
  logic             is_long;
  logic             is_arith;
  logic [CLK_W-1:0] tot_clks;
  logic [RW_W-1:0]  tot_rd;

  assign is_long  = (instr_size == SZ_LONG);
  assign is_arith = (instr_op == OP_ADD) || (instr_op == OP_SUB) || (instr_op == OP_AND) || (instr_op == OP_OR);

  always_comb begin
    tm_clks = STD_REG_BW;
    tm_rd   = 4'h1;
    tm_wr   = 4'h0;
    tm_ok   = 1'b1;
    tm_ea   = 1'b0;
    case (instr_op)
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP, OP_XOR: begin
        tm_ea = 1'b1;
        if (instr_dst == DST_MEM) begin
          tm_ok   = (instr_op != OP_CMP);
          tm_clks = is_long ? STD_MEM_L : STD_MEM_BW;
          tm_wr   = is_long ? 4'h2 : 4'h1;
        end else if (instr_dst == DST_ADDR) begin
          tm_ok   = ((instr_op == OP_ADD) || (instr_op == OP_SUB) || (instr_op == OP_CMP)) &&
                    (instr_size != SZ_BYTE);
          tm_clks = (instr_op == OP_CMP) ? CMP_ADDR : (is_long ? STD_REG_L : STD_ADDR_BW);
        end else if (instr_op == OP_XOR) begin
          tm_ok   = src_data_reg;
          tm_ea   = 1'b0;
          tm_clks = is_long ? XOR_REG_L : STD_REG_BW;
        end else begin
          tm_clks = is_long ? STD_REG_L : STD_REG_BW;
        end
        if (is_arith && is_long && (instr_dst != DST_MEM) && src_reg_or_imm) begin
          tm_clks = STD_REG_L_DIRECT;
        end
      end
      OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE: begin
        tm_ok   = (instr_dst == DST_DATA);
        tm_ea   = 1'b1;
        tm_clks = (instr_op == OP_SIGNED_DIVIDE) ? SDIV_CLKS : UDIV_CLKS;
      end
      OP_SIGNED_MULTIPLY: begin
        tm_ok   = (instr_dst == DST_DATA);
        tm_ea   = 1'b1;
        tm_clks = MUL_BASE + (changes17(src_value) << 1);
      end
      OP_UNSIGNED_MULTIPLY: begin
        tm_ok   = (instr_dst == DST_DATA);
        tm_ea   = 1'b1;
        tm_clks = MUL_BASE + (ones16(src_value) << 1);
      end
      OP_IMMEDIATE: begin
        tm_ok   = (instr_dst != DST_ADDR);
        tm_rd   = is_long ? 4'h3 : 4'h2;
        if (instr_dst == DST_MEM) begin
          tm_ea   = 1'b1;
          tm_clks = is_long ? IMM_MEM_L : IMM_MEM_BW;
          tm_wr   = is_long ? 4'h2 : 4'h1;
        end else begin
          tm_clks = is_long ? IMM_REG_L : IMM_REG_BW;
        end
      end
      OP_SINGLE: begin
        tm_ok = (instr_dst != DST_ADDR);
        if (instr_dst == DST_MEM) begin
          tm_ea   = 1'b1;
          tm_clks = is_long ? STD_MEM_L : STD_MEM_BW;
          tm_wr   = is_long ? 4'h2 : 4'h1;
        end else begin
          tm_clks = is_long ? SGL_REG_L : SGL_REG_BW;
        end
      end
      OP_SHIFT: begin
        if (instr_dst == DST_MEM) begin
          tm_ok   = (instr_size == SZ_WORD);
          tm_ea   = 1'b1;
          tm_clks = SHF_MEM;
          tm_wr   = 4'h1;
        end else begin
          tm_ok   = (instr_dst == DST_DATA);
          tm_clks = (is_long ? SHF_REG_L : SHF_REG_BW) + {2'h0, shift_count, 1'b0};
        end
      end
      OP_SET_COND: begin
        tm_ok = (instr_dst != DST_ADDR);
        if (instr_dst == DST_MEM) begin
          tm_ea   = 1'b1;
          tm_clks = SCC_MEM;
          tm_wr   = 4'h1;
        end else begin
          tm_clks = cond_true ? SCC_TRUE : SCC_FALSE;
        end
      end
      OP_BIT_CHANGE: begin
        if (instr_dst == DST_MEM) begin
          tm_ok   = (instr_size == SZ_BYTE);
          tm_ea   = 1'b1;
          tm_clks = bit_static ? BIT_STAT_MEM : BIT_DYN_MEM;
          tm_rd   = bit_static ? 4'h2 : 4'h1;
          tm_wr   = 4'h1;
        end else begin
          tm_ok   = (instr_dst == DST_DATA) && is_long;
          tm_clks = bit_static ? BIT_STAT_REG : BIT_DYN_REG;
          tm_rd   = bit_static ? 4'h2 : 4'h1;
        end
      end
      default: begin
        tm_ok = 1'b0;
      end
    endcase
  end

  // effective address time taken as given; index size never enters it
  assign tot_clks = tm_clks + (tm_ea ? {1'b0, ea_clks} : 9'h000);
  assign tot_rd   = tm_rd + (tm_ea ? ea_reads : 4'h0);

  // ==========================================================
  // sequencer state
  ict_state_t       state_r;
  logic [CLK_W-1:0] remaining_r;
  logic [RW_W-1:0]  reads_left_r;
  logic [RW_W-1:0]  writes_left_r;
  logic [CLK_W-1:0] elapsed_r;
  logic             accept;
  logic             finish;

  assign accept    = (state_r == ST_IDLE) && instr_valid;
  assign finish    = (state_r == ST_RUN) && (remaining_r == 9'h001) && !bus.stall;
  assign bus.start = (state_r == ST_RUN) && bus.can_issue &&
                     ((reads_left_r != 4'h0) ||
                      ((writes_left_r != 4'h0) && (remaining_r == bus_clks(writes_left_r))));
  assign bus.is_write = (reads_left_r == 4'h0);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept && tm_ok) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (finish) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // remaining clock count, frozen while a bus cycle waits; elapsed count keeps running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remaining_r <= '0;
      elapsed_r   <= '0;
    end else if (accept && tm_ok) begin
      remaining_r <= tot_clks;
      elapsed_r   <= '0;
    end else if (state_r == ST_RUN) begin
      elapsed_r <= elapsed_r + 9'h001;
      if (!bus.stall) begin
        remaining_r <= remaining_r - 9'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reads_left_r  <= '0;
      writes_left_r <= '0;
    end else if (accept && tm_ok) begin
      reads_left_r  <= tot_rd;
      writes_left_r <= tm_wr;
    end else if (bus.start && !bus.is_write) begin
      reads_left_r <= reads_left_r - 4'h1;
    end else if (bus.start) begin
      writes_left_r <= writes_left_r - 4'h1;
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reads_done_r  <= '0;
      writes_done_r <= '0;
    end else if (accept && tm_ok) begin
      reads_done_r  <= '0;
      writes_done_r <= '0;
    end else if (bus.start && !bus.is_write) begin
      reads_done_r <= reads_done_r + 4'h1;
    end else if (bus.start) begin
      writes_done_r <= writes_done_r + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      decode_ready_r <= 1'b1;
      instr_done_r   <= 1'b0;
      illegal_r      <= 1'b0;
      clocks_used_r  <= '0;
    end else begin
      decode_ready_r <= finish || ((state_r == ST_IDLE) && !(accept && tm_ok));
      instr_done_r   <= finish;
      illegal_r      <= accept && !tm_ok;
      if (finish) begin
        clocks_used_r <= elapsed_r + 9'h001;
      end
    end
  end

  assign bus_read_r  = bus.rd_strobe;
  assign bus_write_r = bus.wr_strobe;

  ict_bus_engine u_engine (
    .clk       (clk),
    .reset     (reset),
    .bus_ready (bus_ready),
    .bus       (bus.eng)
  );

  // ==========================================================
  // checks
  logic [CLK_W-1:0] exp_clks_r;
  logic [CLK_W-1:0] waits_r;
  logic [RW_W-1:0]  exp_rd_r;
  logic [RW_W-1:0]  exp_wr_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      exp_clks_r <= '0;
      waits_r    <= '0;
      exp_rd_r   <= '0;
      exp_wr_r   <= '0;
    end else if (accept && tm_ok) begin
      exp_clks_r <= tot_clks;
      waits_r    <= '0;
      exp_rd_r   <= tot_rd;
      exp_wr_r   <= tm_wr;
    end else if (bus.stall) begin
      waits_r <= waits_r + 9'h001;
    end
  end

  a_total_clocks: assert property (@(posedge clk) disable iff (reset)
    instr_done_r |-> clocks_used_r == exp_clks_r + waits_r) else $error("instruction clock total wrong");
  a_read_writes: assert property (@(posedge clk) disable iff (reset)
    instr_done_r |-> (reads_done_r == exp_rd_r) && (writes_done_r == exp_wr_r)) else $error("bus cycle count wrong");
  a_decode_gate: assert property (@(posedge clk) disable iff (reset)
    (accept && tm_ok) |=> !decode_ready_r) else $error("decode opened early");
  a_decode_reopen: assert property (@(posedge clk) disable iff (reset)
    !decode_ready_r |=> (decode_ready_r == instr_done_r)) else $error("decode reopened without end");
  a_bus_four: assert property (@(posedge clk) disable iff (reset)
    $rose(bus_read_r) |-> bus_read_r[*4]) else $error("read cycle shorter than four clocks");
  a_long_direct: assert property (@(posedge clk) disable iff (reset)
    (accept && is_arith && is_long && (instr_dst == DST_DATA) && src_reg_or_imm)
      |-> tm_clks == STD_REG_L_DIRECT) else $error("long direct not eight clocks");
  a_xor_source: assert property (@(posedge clk) disable iff (reset)
    (accept && (instr_op == OP_XOR) && (instr_dst == DST_DATA) && !src_data_reg) |=> illegal_r)
    else $error("bad xor source accepted");
  a_div_time: assert property (@(posedge clk) disable iff (reset)
    (accept && (instr_op == OP_SIGNED_DIVIDE)) |-> tot_clks == SDIV_CLKS + {1'b0, ea_clks})
    else $error("signed divide time wrong");
  a_mul_bound: assert property (@(posedge clk) disable iff (reset)
    (accept && ((instr_op == OP_SIGNED_MULTIPLY) || (instr_op == OP_UNSIGNED_MULTIPLY))) |-> tm_clks <= MUL_MAX)
    else $error("multiply above bound");
  a_byte_addr: assert property (@(posedge clk) disable iff (reset)
    (accept && (instr_dst == DST_ADDR) && (instr_size == SZ_BYTE)) |=> illegal_r && decode_ready_r)
    else $error("byte to address register accepted");
  a_set_cond: assert property (@(posedge clk) disable iff (reset)
    (accept && (instr_op == OP_SET_COND) && (instr_dst == DST_DATA))
      |-> tm_clks == (cond_true ? SCC_TRUE : SCC_FALSE)) else $error("set on condition time wrong");

  c_wait_state: cover property (@(posedge clk) disable iff (reset) bus.stall ##[1:20] instr_done_r);
  c_write_cycle: cover property (@(posedge clk) disable iff (reset) $rose(bus_write_r));
  c_illegal: cover property (@(posedge clk) disable iff (reset) illegal_r);
  c_multiply: cover property (@(posedge clk) disable iff (reset)
    accept && (instr_op == OP_SIGNED_MULTIPLY) && (src_value == 16'h5555));

endmodule // ict_sequencer

//--- ict_sequencer_tb.sv
// testbench for the instruction cycle timing sequencer
// assumes the memory model answers every bus cycle
`timescale 1ns/100ps
module ict_sequencer_tb;
  import ict_pkg::*;
  // ==========================================================
  // signals
  logic              clk;
  logic              reset;
  logic              instr_valid;
  ict_op_t           instr_op;
  ict_size_t         instr_size;
  ict_dst_t          instr_dst;
  logic              src_reg_or_imm;
  logic              src_data_reg;
  logic [EA_W-1:0]   ea_clks;
  logic [RW_W-1:0]   ea_reads;
  logic [15:0]       src_value;
  logic [SHN_W-1:0]  shift_count;
  logic              cond_true;
  logic              bit_static;
  logic              bus_ready;
  logic [3:0]        waits;
  logic              decode_ready_r;
  logic              instr_done_r;
  logic              illegal_r;
  logic              bus_read_r;
  logic              bus_write_r;
  logic [CLK_W-1:0]  clocks_used_r;
  logic [RW_W-1:0]   reads_done_r;
  logic [RW_W-1:0]   writes_done_r;
  int                n_mismatch;
  int                compares;

  ict_sequencer dut (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_size(instr_size), .instr_dst(instr_dst), .src_reg_or_imm(src_reg_or_imm),
    .src_data_reg(src_data_reg), .ea_clks(ea_clks), .ea_reads(ea_reads), .src_value(src_value),
    .shift_count(shift_count), .cond_true(cond_true), .bit_static(bit_static), .bus_ready(bus_ready),
    .decode_ready_r(decode_ready_r), .instr_done_r(instr_done_r), .illegal_r(illegal_r),
    .bus_read_r(bus_read_r), .bus_write_r(bus_write_r), .clocks_used_r(clocks_used_r),
    .reads_done_r(reads_done_r), .writes_done_r(writes_done_r));
  ict_mem_model mem (.clk(clk), .reset(reset), .bus_read_r(bus_read_r), .bus_write_r(bus_write_r),
    .waits(waits), .bus_ready(bus_ready));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // shared tasks
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [CLK_W-1:0] got, input logic [CLK_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // offers one instruction, waits for its end, checks counts
  task automatic tx(input ict_op_t op, input ict_size_t sz, input ict_dst_t dst, input logic ri,
                    input logic dr, input logic [7:0] eac, input logic [3:0] ear, input logic [15:0] sv,
                    input logic [5:0] sh, input logic ct, input logic bs,
                    input logic [8:0] eclk, input logic [3:0] er, input logic [3:0] ew, input logic ill);
    int i;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_size <= sz;
    instr_dst <= dst;
    src_reg_or_imm <= ri;
    src_data_reg <= dr;
    ea_clks <= eac;
    ea_reads <= ear;
    src_value <= sv;
    shift_count <= sh;
    cond_true <= ct;
    bit_static <= bs;
    @(posedge clk);
    instr_valid <= 1'b0;
    for (i = 0; i < 400; i++) begin
      #1;
      if (instr_done_r === 1'b1 || illegal_r === 1'b1) break;
      @(posedge clk);
    end
    if (i == 400) begin
      n_mismatch++;
      print_verdict();
    end
    cmp({8'h00, illegal_r}, {8'h00, ill});
    if (!ill) begin
      cmp(clocks_used_r, eclk);
      cmp({5'h00, reads_done_r}, {5'h00, er});
      cmp({5'h00, writes_done_r}, {5'h00, ew});
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_standard;
    tx(OP_ADD, SZ_LONG, DST_DATA, 1, 1, 0, 0, 0, 0, 0, 0, 9'h008, 1, 0, 0);
    tx(OP_SUB, SZ_LONG, DST_DATA, 0, 1, 4, 1, 0, 0, 0, 0, 9'h00A, 2, 0, 0);
    tx(OP_AND, SZ_WORD, DST_MEM, 0, 1, 8, 2, 0, 0, 0, 0, 9'h010, 3, 1, 0);
    tx(OP_ADD, SZ_BYTE, DST_ADDR, 0, 1, 0, 0, 0, 0, 0, 0, 9'h000, 0, 0, 1);
    tx(OP_ADD, SZ_WORD, DST_ADDR, 0, 1, 0, 0, 0, 0, 0, 0, 9'h008, 1, 0, 0);
  endtask

  task automatic sc_xor;
    tx(OP_XOR, SZ_LONG, DST_DATA, 1, 1, 0, 0, 0, 0, 0, 0, 9'h008, 1, 0, 0);
    tx(OP_XOR, SZ_WORD, DST_DATA, 0, 0, 0, 0, 0, 0, 0, 0, 9'h000, 0, 0, 1);
  endtask

  task automatic sc_muldiv;
    tx(OP_SIGNED_DIVIDE, SZ_WORD, DST_DATA, 0, 1, 4, 1, 0, 0, 0, 0, 9'h0A2, 2, 0, 0);
    tx(OP_UNSIGNED_DIVIDE, SZ_WORD, DST_DATA, 1, 1, 0, 0, 0, 0, 0, 0, 9'h08C, 1, 0, 0);
    tx(OP_UNSIGNED_MULTIPLY, SZ_WORD, DST_DATA, 1, 1, 0, 0, 16'h00FF, 0, 0, 0, 9'h036, 1, 0, 0);
    tx(OP_SIGNED_MULTIPLY, SZ_WORD, DST_DATA, 1, 1, 0, 0, 16'h5555, 0, 0, 0, 9'h046, 1, 0, 0);
    tx(OP_SIGNED_MULTIPLY, SZ_WORD, DST_DATA, 0, 1, 4, 1, 16'h0003, 0, 0, 0, 9'h02E, 2, 0, 0);
  endtask

  task automatic sc_imm_shift;
    tx(OP_IMMEDIATE, SZ_LONG, DST_DATA, 1, 1, 0, 0, 0, 0, 0, 0, 9'h010, 3, 0, 0);
    tx(OP_SHIFT, SZ_WORD, DST_DATA, 1, 1, 0, 0, 0, 6'h03, 0, 0, 9'h00C, 1, 0, 0);
    tx(OP_SHIFT, SZ_LONG, DST_DATA, 1, 1, 0, 0, 0, 6'h3F, 0, 0, 9'h086, 1, 0, 0);
    tx(OP_SHIFT, SZ_WORD, DST_MEM, 0, 1, 4, 1, 0, 0, 0, 0, 9'h00C, 2, 1, 0);
    tx(OP_SHIFT, SZ_LONG, DST_MEM, 0, 1, 4, 1, 0, 0, 0, 0, 9'h000, 0, 0, 1);
  endtask

  task automatic sc_cond_bit;
    tx(OP_SET_COND, SZ_BYTE, DST_DATA, 1, 1, 0, 0, 0, 0, 0, 0, 9'h004, 1, 0, 0);
    tx(OP_SET_COND, SZ_BYTE, DST_DATA, 1, 1, 0, 0, 0, 0, 1, 0, 9'h006, 1, 0, 0);
    tx(OP_BIT_CHANGE, SZ_BYTE, DST_MEM, 0, 1, 4, 1, 0, 0, 0, 0, 9'h00C, 2, 1, 0);
    tx(OP_BIT_CHANGE, SZ_BYTE, DST_MEM, 0, 1, 4, 1, 0, 0, 0, 1, 9'h010, 3, 1, 0);
  endtask

  task automatic sc_waits;
    waits <= 4'h3;
    tx(OP_XOR, SZ_WORD, DST_DATA, 1, 1, 0, 0, 0, 0, 0, 0, 9'h007, 1, 0, 0);
    tx(OP_AND, SZ_WORD, DST_MEM, 0, 1, 8, 2, 0, 0, 0, 0, 9'h013, 3, 1, 0);
    waits <= 4'h0;
    tx(OP_XOR, SZ_WORD, DST_DATA, 1, 1, 0, 0, 0, 0, 0, 0, 9'h004, 1, 0, 0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    compares = 0;
    reset = 1'b1;
    instr_valid = 1'b0;
    instr_op = OP_ADD;
    instr_size = SZ_WORD;
    instr_dst = DST_DATA;
    src_reg_or_imm = 1'b0;
    src_data_reg = 1'b0;
    ea_clks = 8'h00;
    ea_reads = 4'h0;
    src_value = 16'h0000;
    shift_count = 6'h00;
    cond_true = 1'b0;
    bit_static = 1'b0;
    waits = 4'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    sc_standard();
    sc_xor();
    sc_muldiv();
    sc_imm_shift();
    sc_cond_bit();
    sc_waits();
    print_verdict();
  end
endmodule // ict_sequencer_tb
